// file: common/codec_link_if.sv
// link between the host controller and the codec control logic
`timescale 1ns/1ps
interface codec_link_if;
  logic chip_sleep_pin;
  logic wr_en;
  logic rd_en;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic status_out_pin;
  modport dev(
    input chip_sleep_pin, wr_en, rd_en, addr, wdata,
    output rdata, rvalid, status_out_pin
  );
  modport host(
    output chip_sleep_pin, wr_en, rd_en, addr, wdata,
    input rdata, rvalid, status_out_pin
  );
endinterface

// file: common/codec_pkg.sv
// shared constants and types for the codec reset and routing control
package codec_pkg;
  localparam int CLK_HZ = 50_000_000;
  // times in their own units
  localparam int REG_WAIT_US = 1000;
  localparam int PLL_WAIT_MS = 10;
  localparam int CAP_WAIT_MS = 100;
  // least times, exact at this rate so no rounding is lost
  localparam int REG_WAIT_CYC = (CLK_HZ / 1_000_000) * REG_WAIT_US;
  localparam int PLL_WAIT_CYC = (CLK_HZ / 1_000) * PLL_WAIT_MS;
  localparam int CAP_WAIT_CYC = (CLK_HZ / 1_000) * CAP_WAIT_MS;
  // adc start-up length in sample periods
  localparam logic [10:0] ADC_INIT_FS = 11'h423;
  // dc-block corner in mHz at the reference rate in kHz
  localparam int HPF_CORNER_MHZ = 3700;
  localparam int HPF_REF_KHZ = 48;
  // device register indices on the link
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_ROUTE = 2'h1;
  localparam logic [1:0] REG_INPUT = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  // control register bits
  localparam int CTRL_CLK = 0;
  localparam int CTRL_CODEC = 1;
  localparam int CTRL_ADC = 2;
  localparam int CTRL_DAC = 3;
  // route register fields
  localparam int RT_LINE1 = 0;
  localparam int RT_LINE2 = 2;
  localparam int RT_LINE3 = 4;
  localparam int RT_NEG = 6;
  // input register fields
  localparam int IN_GAIN = 0;
  localparam int IN_MODE = 4;
  localparam int IN_PAIR = 5;
  localparam int IN_FILT = 6;
  localparam logic [3:0] GAIN_MAX = 4'hB;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] INPUT_RST = 8'h02;
  // host apb byte offsets
  localparam logic [7:0] A_SLEEP = 8'h00;
  localparam logic [7:0] A_LINK_WR = 8'h04;
  localparam logic [7:0] A_LINK_RD = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_CLK_CFG = 8'h10;
  typedef enum logic [6:0] {
    RT_REF = 7'h01,
    RT_DIRECT = 7'h02,
    RT_DAC_DIFF = 7'h04,
    RT_DAC_SE = 7'h08,
    RT_DAC_POS = 7'h10,
    RT_DAC_NEG = 7'h20,
    RT_INVALID = 7'h40
  } route_t;
  typedef enum logic [4:0] {
    ST_SLEEP = 5'h01,
    ST_CLK_RESET = 5'h02,
    ST_CODEC_RESET = 5'h04,
    ST_RUN = 5'h08,
    ST_FAULT = 5'h10
  } pwr_t;
endpackage

// file: core/codec_ctrl_dev.sv
// codec power sequencing, status pin and analog routing control
`timescale 1ns/1ps
module codec_ctrl_dev #(
  parameter int REG_WAIT_CYC = codec_pkg::REG_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  codec_link_if.dev link,
  input wire logic fault_overcurrent,
  input wire logic fault_overvoltage,
  input wire logic frame_clk_pin,
  input wire logic [5:0] fs_khz,
  output logic pll_run,
  output logic adc_run,
  output logic dac_run,
  output codec_pkg::route_t line1_mode,
  output codec_pkg::route_t line2_mode,
  output codec_pkg::route_t line3_mode,
  output logic in1n_tied,
  output logic in2n_tied,
  output logic [5:0] mic_gain_db,
  output logic mic_gain_ok,
  output logic input_single,
  output logic input_pair2,
  output logic voice_filter,
  output logic adc_data_real,
  output logic [15:0] hpf_corner_mhz
);
  localparam int LW = $clog2(REG_WAIT_CYC + 1);

  typedef struct packed {
    logic [1:0] wake_s;
    logic [1:0] ovc_s;
    logic [1:0] ovv_s;
    logic [1:0] fclk_s;
    logic fclk_prev;
    codec_pkg::pwr_t pwr;
    logic [7:0] ctrl;
    logic [7:0] route;
    logic [7:0] inp;
    logic [LW-1:0] lock_cnt;
    logic [10:0] init_cnt;
    logic init_busy;
    logic [7:0] rdata;
    logic rvalid;
    logic status;
    logic pll;
    logic adc;
    logic dac;
    codec_pkg::route_t l1;
    codec_pkg::route_t l2;
    codec_pkg::route_t l3;
    logic t1;
    logic t2;
    logic [5:0] gain_db;
    logic gain_ok;
    logic adc_real;
    logic [15:0] hpf;
  } dev_state_t;

  dev_state_t s_q;
  dev_state_t s_d;

  // shared decode of the two pair outputs; direct path differs by line only
  function automatic codec_pkg::route_t pair_route(
    input logic [1:0] sel,
    input logic neg
  );
    case (sel)
      2'h0: pair_route = codec_pkg::RT_REF;
      2'h1: pair_route = codec_pkg::RT_DIRECT;
      2'h2: pair_route = neg ? codec_pkg::RT_DAC_SE : codec_pkg::RT_DAC_DIFF;
      default: pair_route = codec_pkg::RT_INVALID;
    endcase
  endfunction

  logic awake;
  logic fault_now;
  logic fs_tick;
  logic running;
  logic adc_on;
  logic neg;

  always_comb begin
    s_d = s_q;
    awake = s_q.wake_s[1];
    fault_now = s_q.ovc_s[1] | s_q.ovv_s[1];
    fs_tick = s_q.fclk_s[1] & ~s_q.fclk_prev;
    // pins cross two flops before any logic looks at them
    s_d.wake_s = {s_q.wake_s[0], link.chip_sleep_pin};
    s_d.ovc_s = {s_q.ovc_s[0], fault_overcurrent};
    s_d.ovv_s = {s_q.ovv_s[0], fault_overvoltage};
    s_d.fclk_s = {s_q.fclk_s[0], frame_clk_pin};
    s_d.fclk_prev = s_q.fclk_s[1];
    s_d.rvalid = 1'b0;
    // power state
    case (s_q.pwr)
      codec_pkg::ST_SLEEP,
      codec_pkg::ST_CLK_RESET,
      codec_pkg::ST_CODEC_RESET,
      codec_pkg::ST_RUN: begin
        if (!awake) begin
          s_d.pwr = codec_pkg::ST_SLEEP;
        end else if (fault_now) begin
          s_d.pwr = codec_pkg::ST_FAULT;
        end else if (!s_q.ctrl[codec_pkg::CTRL_CLK]) begin
          s_d.pwr = codec_pkg::ST_CLK_RESET;
        end else if (!s_q.ctrl[codec_pkg::CTRL_CODEC]) begin
          s_d.pwr = codec_pkg::ST_CODEC_RESET;
        end else begin
          s_d.pwr = codec_pkg::ST_RUN;
        end
      end
      codec_pkg::ST_FAULT: begin
        // only the sleep pin ends a fault
        if (!awake) begin
          s_d.pwr = codec_pkg::ST_SLEEP;
        end
      end
      default: s_d.pwr = codec_pkg::ST_SLEEP;
    endcase
    // register file; lock window 3 short to cover the wake sync lag
    if (!awake) begin
      s_d.ctrl = codec_pkg::CTRL_RST;
      s_d.route = codec_pkg::ROUTE_RST;
      s_d.inp = codec_pkg::INPUT_RST;
      s_d.lock_cnt = LW'(REG_WAIT_CYC - 3);
    end else begin
      if (s_q.lock_cnt != '0) begin
        s_d.lock_cnt = s_q.lock_cnt - LW'(1);
      end
      // writes are ignored in the settle window and after a fault
      if (link.wr_en && s_q.lock_cnt == '0 &&
          s_q.pwr != codec_pkg::ST_FAULT) begin
        case (link.addr)
          codec_pkg::REG_CTRL: s_d.ctrl = link.wdata;
          codec_pkg::REG_ROUTE: s_d.route = link.wdata;
          codec_pkg::REG_INPUT: s_d.inp = link.wdata;
          default: s_d.ctrl = s_q.ctrl;
        endcase
      end
    end
    // block enables follow the registered state
    running = s_q.pwr == codec_pkg::ST_RUN;
    adc_on = running & s_q.ctrl[codec_pkg::CTRL_ADC];
    s_d.pll = s_q.pwr == codec_pkg::ST_CODEC_RESET || running;
    s_d.adc = adc_on;
    s_d.dac = running & s_q.ctrl[codec_pkg::CTRL_DAC];
    s_d.status = awake & s_q.pwr != codec_pkg::ST_FAULT &
                 s_q.pwr != codec_pkg::ST_SLEEP;
    // adc start-up count, restarted on every adc release
    if (!s_q.adc) begin
      s_d.init_cnt = codec_pkg::ADC_INIT_FS;
      s_d.init_busy = 1'b1;
    end else if (fs_tick && s_q.init_cnt != 11'h000) begin
      s_d.init_cnt = s_q.init_cnt - 11'h001;
      s_d.init_busy = s_q.init_cnt != 11'h001;
    end
    s_d.adc_real = s_q.adc & ~s_q.init_busy;
    // analog routing, held at reference outside normal operation
    neg = s_q.route[codec_pkg::RT_NEG];
    if (running) begin
      s_d.l1 = pair_route(s_q.route[codec_pkg::RT_LINE1+:2], neg);
      s_d.l2 = pair_route(s_q.route[codec_pkg::RT_LINE2+:2], neg);
      case (s_q.route[codec_pkg::RT_LINE3+:2])
        2'h0: s_d.l3 = codec_pkg::RT_REF;
        2'h1: s_d.l3 = codec_pkg::RT_DAC_POS;
        2'h2: s_d.l3 = neg ? codec_pkg::RT_REF : codec_pkg::RT_DAC_NEG;
        default: s_d.l3 = codec_pkg::RT_INVALID;
      endcase
    end else begin
      s_d.l1 = codec_pkg::RT_REF;
      s_d.l2 = codec_pkg::RT_REF;
      s_d.l3 = codec_pkg::RT_REF;
    end
    // negative input ties
    s_d.t1 = ~adc_on | s_q.inp[codec_pkg::IN_PAIR];
    s_d.t2 = ~adc_on | ~s_q.inp[codec_pkg::IN_PAIR];
    // gain and filter
    s_d.gain_db = 6'(3 * int'(s_q.inp[codec_pkg::IN_GAIN+:4])) -
                  6'h06;
    s_d.gain_ok = s_q.inp[codec_pkg::IN_GAIN+:4] <= codec_pkg::GAIN_MAX;
    s_d.hpf = 16'((int'(fs_khz) * codec_pkg::HPF_CORNER_MHZ) /
                  codec_pkg::HPF_REF_KHZ);
    // register reads answer one cycle later
    if (link.rd_en) begin
      s_d.rvalid = 1'b1;
      case (link.addr)
        codec_pkg::REG_CTRL: s_d.rdata = s_q.ctrl;
        codec_pkg::REG_ROUTE: s_d.rdata = s_q.route;
        codec_pkg::REG_INPUT: s_d.rdata = s_q.inp;
        default: s_d.rdata = {3'h0, s_q.adc_real, s_q.init_busy,
                              s_q.pwr == codec_pkg::ST_FAULT,
                              s_q.pll, s_q.status};
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{pwr: codec_pkg::ST_SLEEP, ctrl: codec_pkg::CTRL_RST,
               route: codec_pkg::ROUTE_RST, inp: codec_pkg::INPUT_RST,
               lock_cnt: LW'(REG_WAIT_CYC - 3),
               init_cnt: codec_pkg::ADC_INIT_FS, init_busy: 1'b1,
               l1: codec_pkg::RT_REF, l2: codec_pkg::RT_REF,
               l3: codec_pkg::RT_REF, t1: 1'b1, t2: 1'b1,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.rdata = s_q.rdata;
  assign link.rvalid = s_q.rvalid;
  assign link.status_out_pin = s_q.status;
  assign pll_run = s_q.pll;
  assign adc_run = s_q.adc;
  assign dac_run = s_q.dac;
  assign line1_mode = s_q.l1;
  assign line2_mode = s_q.l2;
  assign line3_mode = s_q.l3;
  assign in1n_tied = s_q.t1;
  assign in2n_tied = s_q.t2;
  assign mic_gain_db = s_q.gain_db;
  assign mic_gain_ok = s_q.gain_ok;
  assign input_single = s_q.inp[codec_pkg::IN_MODE];
  assign input_pair2 = s_q.inp[codec_pkg::IN_PAIR];
  assign voice_filter = s_q.inp[codec_pkg::IN_FILT];
  assign adc_data_real = s_q.adc_real;
  assign hpf_corner_mhz = s_q.hpf;
endmodule

// file: core/codec_ctrl_host.sv
// host controller: apb registers, sleep pin and paced link writes
`timescale 1ns/1ps
module codec_ctrl_host #(
  parameter int REG_WAIT_CYC = codec_pkg::REG_WAIT_CYC,
  parameter int PLL_WAIT_CYC = codec_pkg::PLL_WAIT_CYC,
  parameter int CAP_WAIT_CYC = codec_pkg::CAP_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  codec_link_if.host link,
  output logic clk_run,
  output logic [7:0] clk_cfg
);
  localparam int WW = $clog2(CAP_WAIT_CYC + 1);
  localparam int PW = $clog2(PLL_WAIT_CYC + 1);

  typedef struct packed {
    logic wake;
    logic clk_req;
    logic pend;
    logic [1:0] pend_addr;
    logic [7:0] pend_data;
    logic refused;
    logic [WW-1:0] wake_cnt;
    logic [PW-1:0] pll_cnt;
    logic [7:0] shadow;
    logic [1:0] sts_s;
    logic rd_busy;
    logic rd_ok;
    logic [7:0] rd_data;
    logic [7:0] cfg;
    logic wr_en;
    logic rd_en;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic [31:0] prdata;
    logic rdy;
    logic err;
    logic run;
  } host_state_t;

  host_state_t s_q;
  host_state_t s_d;

  logic wake_ok;
  logic cap_ok;
  logic pll_ok;
  logic gate;
  logic acc;
  logic mapped;
  logic [7:0] wv;

  always_comb begin
    s_d = s_q;
    wake_ok = s_q.wake_cnt >= WW'(REG_WAIT_CYC);
    cap_ok = s_q.wake_cnt >= WW'(CAP_WAIT_CYC);
    pll_ok = s_q.pll_cnt >= PW'(PLL_WAIT_CYC);
    acc = psel & penable;
    mapped = paddr == codec_pkg::A_SLEEP || paddr == codec_pkg::A_LINK_WR ||
             paddr == codec_pkg::A_LINK_RD || paddr == codec_pkg::A_STATUS ||
             paddr == codec_pkg::A_CLK_CFG;
    s_d.sts_s = {s_q.sts_s[0], link.status_out_pin};
    s_d.wr_en = 1'b0;
    s_d.rd_en = 1'b0;
    s_d.rdy = psel & ~penable;
    s_d.err = psel & ~penable & ~mapped;
    // wait counters saturate at their longest figure
    if (!s_q.wake) begin
      s_d.wake_cnt = '0;
    end else if (!cap_ok) begin
      s_d.wake_cnt = s_q.wake_cnt + WW'(1);
    end
    if (!s_q.shadow[codec_pkg::CTRL_CLK]) begin
      s_d.pll_cnt = '0;
    end else if (!pll_ok) begin
      s_d.pll_cnt = s_q.pll_cnt + PW'(1);
    end
    // a pending link write leaves only once its wait has passed
    wv = s_q.pend_data;
    case (s_q.pend_addr)
      codec_pkg::REG_CTRL: begin
        if (!wv[codec_pkg::CTRL_CLK]) begin
          wv[codec_pkg::CTRL_CODEC] = 1'b0;
        end
        gate = s_q.clk_req;
        if (wv[codec_pkg::CTRL_CODEC] &&
            !s_q.shadow[codec_pkg::CTRL_CODEC]) begin
          gate = gate & pll_ok & cap_ok;
        end
      end
      codec_pkg::REG_ROUTE:
        gate = cap_ok & s_q.shadow[codec_pkg::CTRL_CODEC];
      codec_pkg::REG_INPUT: gate = cap_ok;
      default: gate = 1'b1;
    endcase
    if (!s_q.wake) begin
      s_d.pend = 1'b0;
      s_d.shadow = codec_pkg::CTRL_RST;
    end else if (s_q.pend && wake_ok && gate && !s_q.rd_busy) begin
      s_d.pend = 1'b0;
      s_d.wr_en = 1'b1;
      s_d.addr = s_q.pend_addr;
      s_d.wdata = wv;
      if (s_q.pend_addr == codec_pkg::REG_CTRL) begin
        s_d.shadow = wv;
      end
    end
    // read answer capture
    if (link.rvalid && s_q.rd_busy) begin
      s_d.rd_busy = 1'b0;
      s_d.rd_ok = 1'b1;
      s_d.rd_data = link.rdata;
    end
    // apb register reads, sampled in the setup cycle
    if (psel && !penable) begin
      case (paddr)
        codec_pkg::A_SLEEP: s_d.prdata = {30'h0, s_q.clk_req, s_q.wake};
        codec_pkg::A_LINK_WR: s_d.prdata = {21'h0, s_q.pend,
                                            s_q.pend_addr, s_q.pend_data};
        codec_pkg::A_LINK_RD: s_d.prdata = {22'h0, s_q.rd_busy,
                                            s_q.rd_ok, s_q.rd_data};
        codec_pkg::A_STATUS: s_d.prdata = {26'h0, s_q.refused, s_q.pend,
                                           pll_ok, cap_ok, wake_ok,
                                           s_q.sts_s[1]};
        codec_pkg::A_CLK_CFG: s_d.prdata = {24'h0, s_q.cfg};
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
    // apb writes take effect at the access edge
    if (acc && pwrite) begin
      case (paddr)
        codec_pkg::A_SLEEP: begin
          s_d.wake = pwdata[0];
          s_d.clk_req = pwdata[1];
        end
        codec_pkg::A_LINK_WR: begin
          if (s_q.pend || !s_q.wake) begin
            s_d.refused = 1'b1;
          end else begin
            s_d.pend = 1'b1;
            s_d.pend_addr = pwdata[9:8];
            s_d.pend_data = pwdata[7:0];
          end
        end
        codec_pkg::A_LINK_RD: begin
          if (s_q.rd_busy || s_d.wr_en || !wake_ok) begin
            s_d.refused = 1'b1;
          end else begin
            s_d.rd_en = 1'b1;
            s_d.rd_busy = 1'b1;
            s_d.rd_ok = 1'b0;
            s_d.addr = pwdata[1:0];
          end
        end
        codec_pkg::A_STATUS: begin
          // the clear always wins; refusals come only from writes to other addresses
          if (pwdata[5]) begin
            s_d.refused = 1'b0;
          end
        end
        codec_pkg::A_CLK_CFG: begin
          if (!s_q.wake || !s_q.shadow[codec_pkg::CTRL_CLK]) begin
            s_d.cfg = pwdata[7:0];
          end else begin
            s_d.refused = 1'b1;
          end
        end
        default: s_d.err = s_q.err;
      endcase
    end
    // clocks may stop only asleep or in clock reset
    s_d.run = s_q.clk_req |
              (s_q.wake & s_q.shadow[codec_pkg::CTRL_CLK]);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{shadow: codec_pkg::CTRL_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = psel & penable & s_q.rdy;
  assign pslverr = psel & penable & s_q.err;
  assign link.chip_sleep_pin = s_q.wake;
  assign link.wr_en = s_q.wr_en;
  assign link.rd_en = s_q.rd_en;
  assign link.addr = s_q.addr;
  assign link.wdata = s_q.wdata;
  assign clk_run = s_q.run;
  assign clk_cfg = s_q.cfg;
endmodule

// file: test/codec_link_monitor.sv
// assertion checker watching the link between host and codec control
`timescale 1ns/1ps
module codec_link_monitor #(
  parameter int REG_WAIT_CYC = codec_pkg::REG_WAIT_CYC,
  parameter int PLL_WAIT_CYC = codec_pkg::PLL_WAIT_CYC,
  parameter int CAP_WAIT_CYC = codec_pkg::CAP_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_sleep_pin,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic status_out_pin
);
  logic [31:0] wake_cnt_q;
  logic [31:0] pll_cnt_q;
  logic clk_hold_q;
  logic codec_hold_q;
  logic ctrl_wr;
  assign ctrl_wr = wr_en && (addr == codec_pkg::REG_CTRL);
  ////////////////////////////////////////////////////////////////////////////
  // saturating counts so a long run never wraps back under a bound
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_cnt_q <= 32'h0;
      pll_cnt_q <= 32'h0;
      clk_hold_q <= 1'b0;
      codec_hold_q <= 1'b0;
    end else if (!chip_sleep_pin) begin
      wake_cnt_q <= 32'h0;
      pll_cnt_q <= 32'h0;
      clk_hold_q <= 1'b0;
      codec_hold_q <= 1'b0;
    end else begin
      if (wake_cnt_q != 32'hFFFFFFFF) wake_cnt_q <= wake_cnt_q + 32'h1;
      if (clk_hold_q && pll_cnt_q != 32'hFFFFFFFF)
        pll_cnt_q <= pll_cnt_q + 32'h1;
      if (ctrl_wr) begin
        clk_hold_q <= wdata[codec_pkg::CTRL_CLK];
        codec_hold_q <= wdata[codec_pkg::CTRL_CODEC];
        if (!clk_hold_q || !wdata[codec_pkg::CTRL_CLK]) pll_cnt_q <= 32'h0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_read_req;
    rd_en;
  endsequence
  sequence s_read_ans;
    rvalid ##1 !rvalid;
  endsequence
  a_read_answer: assert property (s_read_req |=> s_read_ans)
    else $error("read strobe not answered next cycle");
  a_rvalid_cause: assert property (rvalid |-> $past(rd_en))
    else $error("read answer without request");
  a_status_wake: assert property (
    $rose(chip_sleep_pin) |-> ##[1:8] (status_out_pin || !chip_sleep_pin))
    else $error("status pin did not rise after wake");
  a_status_sleep: assert property (
    !chip_sleep_pin [*5] |-> !status_out_pin)
    else $error("status pin high while asleep");
  a_status_latch: assert property (
    $rose(status_out_pin) |-> chip_sleep_pin && wake_cnt_q < 8)
    else $error("status pin recovered without sleep");
  a_link_awake: assert property (
    (wr_en || rd_en) |-> chip_sleep_pin && wake_cnt_q >= REG_WAIT_CYC - 1)
    else $error("link access too early after wake");
  a_ctrl_order: assert property (
    ctrl_wr && !wdata[codec_pkg::CTRL_CLK] |-> !wdata[codec_pkg::CTRL_CODEC])
    else $error("clock hold cleared with codec hold set");
  a_codec_wait: assert property (
    ctrl_wr && wdata[codec_pkg::CTRL_CODEC] && !codec_hold_q
    |-> clk_hold_q && pll_cnt_q >= PLL_WAIT_CYC - 2)
    else $error("codec hold released before pll settled");
  a_route_gate: assert property (
    wr_en && addr == codec_pkg::REG_ROUTE
    |-> codec_hold_q && wake_cnt_q >= CAP_WAIT_CYC - 1)
    else $error("route written too early");
  a_input_gate: assert property (
    wr_en && addr == codec_pkg::REG_INPUT |-> wake_cnt_q >= CAP_WAIT_CYC - 1)
    else $error("input setup written too early");
endmodule

// file: test/codec_reset_route_control_tb_top.sv
// testbench joining host controller and codec control end to end
`timescale 1ns/1ps
module codec_reset_route_control_tb_top;
  localparam int HREG = 20;
  localparam int PLLW = 30;
  localparam int CAPW = 60;
  typedef struct packed {
    logic [7:0] rt;
    logic [7:0] inp;
    codec_pkg::route_t l1;
    codec_pkg::route_t l2;
    codec_pkg::route_t l3;
    logic [5:0] db;
    logic ok;
    logic [4:0] misc;
  } row_t;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0] paddr, clk_cfg;
  logic [31:0] pwdata, prdata, rdv;
  logic fault_oc, fault_ov, frame_clk, clk_run, pll_run, adc_run, dac_run;
  logic in1n_tied, in2n_tied, mic_gain_ok, input_single, input_pair2;
  logic voice_filter, adc_data_real;
  logic [5:0] fs_khz, mic_gain_db;
  logic [15:0] hpf_corner_mhz;
  codec_pkg::route_t line1_mode, line2_mode, line3_mode;
  int failures = 0, compares = 0;
  // misc = single, pair2, voice, in1n tied, in2n tied
  row_t rows [5] = '{
    '{8'h00, 8'h00, codec_pkg::RT_REF, codec_pkg::RT_REF,
      codec_pkg::RT_REF, 6'h3A, 1'b1, 5'h01},
    '{8'h15, 8'h02, codec_pkg::RT_DIRECT, codec_pkg::RT_DIRECT,
      codec_pkg::RT_DAC_POS, 6'h00, 1'b1, 5'h01},
    '{8'h2A, 8'h7B, codec_pkg::RT_DAC_DIFF, codec_pkg::RT_DAC_DIFF,
      codec_pkg::RT_DAC_NEG, 6'h1B, 1'b1, 5'h1E},
    '{8'h6A, 8'h1C, codec_pkg::RT_DAC_SE, codec_pkg::RT_DAC_SE,
      codec_pkg::RT_REF, 6'h1E, 1'b0, 5'h11},
    '{8'h3F, 8'h20, codec_pkg::RT_INVALID, codec_pkg::RT_INVALID,
      codec_pkg::RT_INVALID, 6'h3A, 1'b1, 5'h0A}};
  codec_link_if link();
  codec_ctrl_host #(.REG_WAIT_CYC(HREG), .PLL_WAIT_CYC(PLLW),
    .CAP_WAIT_CYC(CAPW)) codec_ctrl_host_inst (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link.host), .clk_run(clk_run), .clk_cfg(clk_cfg));
  codec_ctrl_dev #(.REG_WAIT_CYC(HREG)) codec_ctrl_dev_inst (.clk(clk),
    .reset_n(reset_n), .link(link.dev), .fault_overcurrent(fault_oc),
    .fault_overvoltage(fault_ov), .frame_clk_pin(frame_clk),
    .fs_khz(fs_khz), .pll_run(pll_run), .adc_run(adc_run),
    .dac_run(dac_run), .line1_mode(line1_mode), .line2_mode(line2_mode),
    .line3_mode(line3_mode), .in1n_tied(in1n_tied), .in2n_tied(in2n_tied),
    .mic_gain_db(mic_gain_db), .mic_gain_ok(mic_gain_ok),
    .input_single(input_single), .input_pair2(input_pair2),
    .voice_filter(voice_filter), .adc_data_real(adc_data_real),
    .hpf_corner_mhz(hpf_corner_mhz));
  codec_link_monitor #(.REG_WAIT_CYC(HREG), .PLL_WAIT_CYC(PLLW),
    .CAP_WAIT_CYC(CAPW)) codec_link_monitor_inst (.clk(clk),
    .reset_n(reset_n), .chip_sleep_pin(link.chip_sleep_pin),
    .wr_en(link.wr_en), .rd_en(link.rd_en), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid),
    .status_out_pin(link.status_out_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timed_out(input string nm);
    failures++;
    $display("unexpected %s expected done seen timeout", nm);
    final_report;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // starts one edge later so psel is never set twice in one time step
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(negedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) timed_out("pready");
    rdv = prdata;
    errv = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic stat_wait(input int b, input logic v);
    int n;
    n = 0;
    apb(1'b0, codec_pkg::A_STATUS, 32'h0);
    while (rdv[b] !== v && n < 300) begin
      apb(1'b0, codec_pkg::A_STATUS, 32'h0);
      n++;
    end
    if (n == 300) timed_out("status");
  endtask
  task automatic link_wr(input logic [1:0] i, input logic [7:0] d);
    apb(1'b1, codec_pkg::A_LINK_WR, {22'h0, i, d});
    stat_wait(4, 1'b0);
    repeat (3) @(posedge clk);
  endtask
  task automatic link_rd(input logic [1:0] i, input logic [7:0] e,
                         input string nm);
    int n;
    n = 0;
    apb(1'b1, codec_pkg::A_LINK_RD, {30'h0, i});
    apb(1'b0, codec_pkg::A_LINK_RD, 32'h0);
    while (rdv[9] !== 1'b0 && n < 20) begin
      apb(1'b0, codec_pkg::A_LINK_RD, 32'h0);
      n++;
    end
    if (n == 20) timed_out("link read");
    chk("read_ok", 32'h1, rdv[8]);
    chk(nm, e, rdv[7:0]);
  endtask
  // two cycles high, two low: wide enough for the two-flop sync
  task automatic frames(input int cnt);
    repeat (cnt) begin
      frame_clk <= 1'b1;
      repeat (2) @(posedge clk);
      frame_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {reset_n, psel, penable, pwrite, fault_oc, fault_ov, frame_clk} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fs_khz = 6'd48;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("sleep_pin", 32'h0, link.chip_sleep_pin);
    chk("line1", codec_pkg::RT_REF, line1_mode);
    chk("tied", 32'h3, {in1n_tied, in2n_tied});
    apb(1'b1, codec_pkg::A_SLEEP, 32'h3);
    apb(1'b1, codec_pkg::A_CLK_CFG, 32'h5A);
    chk("clk_cfg", 32'h5A, clk_cfg);
    stat_wait(0, 1'b1);
    chk("status", 32'h1, link.status_out_pin);
    chk("clk_run", 32'h1, clk_run);
    stat_wait(1, 1'b1);
    link_rd(codec_pkg::REG_CTRL, 8'h00, "ctrl");
    link_rd(codec_pkg::REG_INPUT, codec_pkg::INPUT_RST, "input");
    chk("pll", 32'h0, pll_run);
    link_wr(codec_pkg::REG_CTRL, 8'h01);
    chk("pll", 32'h1, pll_run);
    chk("run", 32'h0, {adc_run, dac_run});
    apb(1'b1, codec_pkg::A_CLK_CFG, 32'hA5);
    chk("clk_cfg", 32'h5A, clk_cfg);
    apb(1'b0, codec_pkg::A_STATUS, 32'h0);
    chk("refused", 32'h1, rdv[5]);
    apb(1'b1, codec_pkg::A_STATUS, 32'h20);
    stat_wait(3, 1'b1);
    stat_wait(2, 1'b1);
    link_wr(codec_pkg::REG_CTRL, 8'h0F);
    chk("run", 32'h3, {adc_run, dac_run});
    chk("data_real", 32'h0, adc_data_real);
    foreach (rows[i]) begin
      link_wr(codec_pkg::REG_ROUTE, rows[i].rt);
      link_wr(codec_pkg::REG_INPUT, rows[i].inp);
      chk("line1", rows[i].l1, line1_mode);
      chk("line2", rows[i].l2, line2_mode);
      chk("line3", rows[i].l3, line3_mode);
      chk("gain", rows[i].db, mic_gain_db);
      chk("gain_ok", rows[i].ok, mic_gain_ok);
      chk("input", rows[i].misc, {input_single, input_pair2, voice_filter,
        in1n_tied, in2n_tied});
    end
    frames(1058);
    repeat (4) @(posedge clk);
    chk("data_real", 32'h0, adc_data_real);
    frames(1);
    repeat (4) @(posedge clk);
    chk("data_real", 32'h1, adc_data_real);
    chk("hpf", 32'h0E74, hpf_corner_mhz);
    fs_khz <= 6'd8;
    repeat (4) @(posedge clk);
    chk("hpf", 32'h0268, hpf_corner_mhz);
    link_wr(codec_pkg::REG_CTRL, 8'h0B);
    chk("run", 32'h1, {adc_run, dac_run});
    link_wr(codec_pkg::REG_CTRL, 8'h0D);
    chk("run", 32'h0, {adc_run, dac_run});
    chk("pll", 32'h1, pll_run);
    chk("line1", codec_pkg::RT_REF, line1_mode);
    chk("tied", 32'h3, {in1n_tied, in2n_tied});
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 32'h1, errv);
    fault_oc <= 1'b1;
    repeat (6) @(posedge clk);
    fault_oc <= 1'b0;
    repeat (30) @(posedge clk);
    chk("status", 32'h0, link.status_out_pin);
    chk("pll", 32'h0, pll_run);
    apb(1'b1, codec_pkg::A_SLEEP, 32'h0);
    repeat (6) @(posedge clk);
    chk("status", 32'h0, link.status_out_pin);
    apb(1'b1, codec_pkg::A_SLEEP, 32'h3);
    stat_wait(1, 1'b1);
    chk("status", 32'h1, link.status_out_pin);
    link_rd(codec_pkg::REG_CTRL, 8'h00, "ctrl");
    fault_ov <= 1'b1;
    repeat (6) @(posedge clk);
    fault_ov <= 1'b0;
    repeat (6) @(posedge clk);
    chk("status", 32'h0, link.status_out_pin);
    final_report;
  end
endmodule
